// >>> rtl/low_power_timebase.sv
// self-timed measurement pacing
// assumes run_i and rate_i come from logic on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "prox_consts.svh"

module low_power_timebase #(
	parameter int unsigned BASE_CYCLES = `RATE_BASE_CYCLES,
	parameter int          CW          = `RATE_CNT_W
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              run_i,
	input  wire logic [`RATE_W-1:0] rate_i,
	output logic                   tick_o
);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} tb_state_t;

	tb_state_t       s;
	tb_state_t       next_s;
	logic [CW-1:0]   period;

	// each rate code step halves the period
	assign period = CW'(BASE_CYCLES >> rate_i);

	// counter stands at zero while stopped, so the first tick
	// comes one whole period after the enable
	always_comb begin
		next_s      = s;
		next_s.tick = 1'b0;
		if (!run_i) begin
			next_s.cnt = '0;
		end else if (s.cnt >= period - 1'b1) begin
			next_s.cnt  = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick_o = s.tick;

endmodule : low_power_timebase
`default_nettype wire

// >>> rtl/prox_consts.svh
// constants of the proximity sensor control block
// assumes a 40 MHz system clock and an I2C controller outside
// Operation
// R1 - Seventeen 8-bit registers, all reachable over the I2C target port.
// R2 - Target port works in standard, fast and high-speed modes.
// R3 - Answer only the fixed 7-bit target address 13h.
// R4 - Address byte low bit gives direction: 26h write, 27h read.
// R5 - Register addresses run from 80h (register 0) to 90h (register 16).
// R6 - Register 80h is the command register with starts and ready flag.
// R7 - Command bit 7 is a lock flag, always reads 1, writes ignored.
// R8 - Command bit 5 reads 1 when a finished result is stored.
// R9 - Reading result high or low byte clears the ready flag.
// R10 - Writing 1 to command bit 3 starts one on-demand measurement.
// R11 - Command bit 1 enables periodic measurements, read-write.
// R12 - Command bit 0 enables the self-timed sequencer and its timebase.
// R13 - Self-timed enable alone starts nothing; periodic enable is also needed.
// R14 - Host sets self-timed enable before or with periodic enable.
// R15 - On-demand requests are ignored while self-timed enable is 1.
// R16 - Rate register changes only while self-timed enable is 0.
// R17 - Interrupt output is open drain, pulls low when asserted.
// R18 - Result is 16 bits: high byte at 87h, low byte at 88h.
`ifndef PROX_CONSTS_SVH
`define PROX_CONSTS_SVH

// -----------------------------------------------------------------
// bus addressing
// -----------------------------------------------------------------
`define DEV_ADDR7          7'h13
`define ADDR_BYTE_WR       8'h26
`define ADDR_BYTE_RD       8'h27
`define REG_FIRST          8'h80
`define REG_LAST           8'h90
`define REG_COUNT          17
`define REG_CMD            8'h80
`define REG_ID             8'h81
`define REG_RATE           8'h82
`define REG_LED            8'h83
`define REG_RES_HI         8'h87
`define REG_RES_LO         8'h88
`define INT_CTL_INDEX      5'h09

// -----------------------------------------------------------------
// fields and reset values
// -----------------------------------------------------------------
`define CMD_LOCK_BIT       7
`define CMD_READY_BIT      5
`define CMD_SINGLE_BIT     3
`define CMD_PERIODIC_BIT   1
`define CMD_SELFTIMED_BIT  0
`define INT_READY_EN_BIT   3
`define RATE_W             3
`define LED_W              6
`define RATE_RESET         3'h0
`define LED_RESET          6'h02
`define RESULT_W           16

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CLK_MHZ            40
`define CONV_TIME_NS       10000
`define CONV_CYCLES        ((`CONV_TIME_NS * `CLK_MHZ + 999) / 1000)
`define CONV_CNT_W         12
`define RATE_BASE_MS       512
`define RATE_BASE_CYCLES   (`RATE_BASE_MS * `CLK_MHZ * 1000)
`define RATE_CNT_W         25

`endif

// >>> rtl/prox_pkg.sv
// types shared by the proximity sensor control block
// assumes prox_consts.svh is on the include path
`default_nettype none
`include "prox_consts.svh"

package prox_pkg;

	// -------------------------------------------------------------
	// target port sequencing
	// -------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_PTR,
		ST_PTR_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_TX,
		ST_TX_ACK
	} i2c_state_t;

	// -------------------------------------------------------------
	// whole state of the top module
	// -------------------------------------------------------------
	typedef struct packed {
		i2c_state_t                     st;
		logic [3:0]                     bit_cnt;
		logic [7:0]                     shift;
		logic [7:0]                     tx;
		logic                           rw;
		logic                           nack;
		logic [7:0]                     ptr;
		logic                           scl_d;
		logic                           sda_d;
		logic                           sda_oe;
		logic                           selftimed;
		logic                           periodic;
		logic                           single_pend;
		logic                           busy;
		logic [`CONV_CNT_W-1:0]         conv_cnt;
		logic [`RATE_W-1:0]             rate;
		logic [`LED_W-1:0]              led_set;
		logic [`LED_W-1:0]              led_out;
		logic                           ready;
		logic [`RESULT_W-1:0]           result;
		logic [`REG_COUNT-1:0][7:0]     plain;
		logic                           int_oe;
	} top_state_t;

endpackage : prox_pkg
`default_nettype wire

// >>> rtl/prox_sensor_top.sv
// proximity sensor control: I2C target port, register file
// and measurement sequencer
// assumes the analog front end presents meas_sample_i on clk_i
// and that pull-ups on SDA and INT sit outside
`timescale 1ns/1ps
`default_nettype none
`include "prox_consts.svh"

module prox_sensor_top #(
	parameter int unsigned RATE_BASE_CYCLES = `RATE_BASE_CYCLES,
	parameter logic [7:0]  ID_VALUE         = 8'h5A // arbitrary value
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe_o,
	output logic                      int_o,
	output logic                      int_oe_o,
	input  wire logic [`RESULT_W-1:0] meas_sample_i,
	output logic                      meas_active_o,
	output logic [`LED_W-1:0]         led_current_o
);

	// -------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------
	prox_pkg::top_state_t s;
	prox_pkg::top_state_t next_s;

	logic [1:0] pins_sync;
	logic       scl_s;
	logic       sda_s;
	logic       tick;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;
	logic       load_tx;
	logic       rd_clear;
	logic       conv_done;
	logic [7:0] wdata;
	logic [7:0] rdata;

	// -------------------------------------------------------------
	// pin sampling and pacing
	// -------------------------------------------------------------

	// both pins share one synchroniser so their delays match
	sync2 #(
		.WIDTH (2)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({scl_i, sda_i}),
		.sync_o  (pins_sync)
	);

	assign scl_s = pins_sync[1];
	assign sda_s = pins_sync[0];

	// periodic pacing needs both enables
	low_power_timebase #(
		.BASE_CYCLES (RATE_BASE_CYCLES),
		.CW          (`RATE_CNT_W)
	) u_timebase (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (s.selftimed & s.periodic), // R12 R13
		.rate_i (s.rate),
		.tick_o (tick)
	);

	// -------------------------------------------------------------
	// bus conditions
	// -------------------------------------------------------------

	// high-speed mode leaves about two clocks of SCL high time,
	// which is the least this edge detection can resolve
	assign scl_rise   = scl_s & ~s.scl_d; // R2
	assign scl_fall   = ~scl_s & s.scl_d;
	assign start_cond = scl_s & s.scl_d & s.sda_d & ~sda_s;
	assign stop_cond  = scl_s & s.scl_d & ~s.sda_d & sda_s;

	// -------------------------------------------------------------
	// register read mux
	// -------------------------------------------------------------
	function automatic logic [7:0] read_reg(
		input prox_pkg::top_state_t v,
		input logic [7:0]           a
	);
		logic [7:0] d;
		d = 8'h00;
		if (a >= `REG_FIRST && a <= `REG_LAST) begin // R1 R5
			case (a)
				`REG_CMD: begin // R6
					d[`CMD_LOCK_BIT]      = 1'b1;       // R7
					d[`CMD_READY_BIT]     = v.ready;    // R8
					d[`CMD_SINGLE_BIT]    = v.single_pend;
					d[`CMD_PERIODIC_BIT]  = v.periodic; // R11
					d[`CMD_SELFTIMED_BIT] = v.selftimed; // R12
				end
				`REG_ID: begin
					d = ID_VALUE;
				end
				`REG_RATE: begin
					d[`RATE_W-1:0] = v.rate;
				end
				`REG_LED: begin
					d[`LED_W-1:0] = v.led_set;
				end
				`REG_RES_HI: begin
					d = v.result[15:8]; // R18
				end
				`REG_RES_LO: begin
					d = v.result[7:0]; // R18
				end
				default: begin
					d = v.plain[5'(a - `REG_FIRST)];
				end
			endcase
		end
		return d;
	endfunction : read_reg

	assign rdata = read_reg(s, s.ptr);
	assign wdata = s.shift;

	// -------------------------------------------------------------
	// next state
	// -------------------------------------------------------------
	always_comb begin
		next_s       = s;
		next_s.scl_d = scl_s;
		next_s.sda_d = sda_s;
		load_tx      = 1'b0;
		rd_clear     = 1'b0;
		conv_done    = 1'b0;

		// target port; a start restarts from any state
		if (start_cond) begin
			next_s.st      = prox_pkg::ST_ADDR;
			next_s.bit_cnt = 4'h0;
		end else if (stop_cond) begin
			next_s.st = prox_pkg::ST_IDLE;
		end else begin
			unique case (s.st)
				prox_pkg::ST_IDLE: begin
					next_s.bit_cnt = 4'h0;
				end
				prox_pkg::ST_ADDR,
				prox_pkg::ST_PTR,
				prox_pkg::ST_WDATA: begin
					if (scl_rise && s.bit_cnt < 4'h8) begin
						next_s.shift   = {s.shift[6:0], sda_s};
						next_s.bit_cnt = s.bit_cnt + 4'h1;
					end else if (scl_fall && s.bit_cnt == 4'h8) begin
						next_s.bit_cnt = 4'h0;
						if (s.st == prox_pkg::ST_ADDR) begin
							// other targets on the bus are left alone
							if (s.shift == `ADDR_BYTE_WR || s.shift == `ADDR_BYTE_RD) begin // R3 R4
								next_s.rw = s.shift[0]; // R4
								next_s.st = prox_pkg::ST_ADDR_ACK;
							end else begin
								next_s.st = prox_pkg::ST_IDLE;
							end
						end else if (s.st == prox_pkg::ST_PTR) begin
							next_s.ptr = wdata;
							next_s.st  = prox_pkg::ST_PTR_ACK;
						end else begin
							next_s.ptr = s.ptr + 8'h01;
							next_s.st  = prox_pkg::ST_WDATA_ACK;
						end
					end
				end
				prox_pkg::ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (s.rw) begin
							load_tx = 1'b1;
						end else begin
							next_s.st = prox_pkg::ST_PTR;
						end
					end
				end
				prox_pkg::ST_PTR_ACK,
				prox_pkg::ST_WDATA_ACK: begin
					if (scl_fall) begin
						next_s.st = prox_pkg::ST_WDATA;
					end
				end
				prox_pkg::ST_TX: begin
					if (scl_fall) begin
						if (s.bit_cnt == 4'h7) begin
							next_s.st = prox_pkg::ST_TX_ACK;
						end else begin
							next_s.tx      = {s.tx[6:0], 1'b0};
							next_s.bit_cnt = s.bit_cnt + 4'h1;
						end
					end
				end
				prox_pkg::ST_TX_ACK: begin
					if (scl_rise) begin
						next_s.nack = sda_s;
					end else if (scl_fall) begin
						if (s.nack) begin
							next_s.st = prox_pkg::ST_IDLE;
						end else begin
							load_tx = 1'b1;
						end
					end
				end
			endcase
		end

		// fetch the next read byte; pointer advances past it
		if (load_tx) begin
			next_s.tx      = rdata;
			next_s.ptr     = s.ptr + 8'h01;
			next_s.bit_cnt = 4'h0;
			next_s.st      = prox_pkg::ST_TX;
			if (s.ptr == `REG_RES_HI || s.ptr == `REG_RES_LO) begin
				rd_clear = 1'b1; // R9
			end
		end

		// register writes land when the data byte completes
		if (!start_cond && !stop_cond && s.st == prox_pkg::ST_WDATA
		    && scl_fall && s.bit_cnt == 4'h8) begin
			if (s.ptr == `REG_CMD) begin // R6
				next_s.selftimed = wdata[`CMD_SELFTIMED_BIT]; // R12
				next_s.periodic  = wdata[`CMD_PERIODIC_BIT];  // R11
				// self-timed mode owns the sequencer
				if (wdata[`CMD_SINGLE_BIT] && !s.selftimed
				    && !wdata[`CMD_SELFTIMED_BIT] && !s.busy) begin // R15
					next_s.single_pend = 1'b1; // R10
				end
			end else if (s.ptr == `REG_RATE) begin
				// changing pace mid-run would skew the period
				if (!s.selftimed) begin // R16
					next_s.rate = wdata[`RATE_W-1:0];
				end
			end else if (s.ptr == `REG_LED) begin
				next_s.led_set = wdata[`LED_W-1:0];
			end else if (s.ptr == `REG_ID || s.ptr == `REG_RES_HI
			             || s.ptr == `REG_RES_LO) begin
				next_s.plain = s.plain;
			end else if (s.ptr > `REG_CMD && s.ptr <= `REG_LAST) begin // R1 R5
				next_s.plain[5'(s.ptr - `REG_FIRST)] = wdata;
			end
		end

		// open drain: only ever pull low
		next_s.sda_oe = (next_s.st == prox_pkg::ST_ADDR_ACK)
		              || (next_s.st == prox_pkg::ST_PTR_ACK)
		              || (next_s.st == prox_pkg::ST_WDATA_ACK)
		              || (next_s.st == prox_pkg::ST_TX && !next_s.tx[7]);

		// measurement sequencer
		if (s.busy) begin
			if (s.conv_cnt == `CONV_CNT_W'(`CONV_CYCLES - 1)) begin
				conv_done          = 1'b1;
				next_s.busy        = 1'b0;
				next_s.single_pend = 1'b0;
				next_s.result      = meas_sample_i; // R10 R18
			end else begin
				next_s.conv_cnt = s.conv_cnt + 1'b1;
			end
		end else if (s.single_pend || tick) begin // R10 R13
			next_s.busy     = 1'b1;
			next_s.conv_cnt = '0;
		end

		// a result finishing in the clearing cycle keeps the flag
		next_s.ready = (s.ready & ~rd_clear) | conv_done; // R8 R9

		// current setting is taken over only outside self-timed runs
		if (!next_s.selftimed) begin
			next_s.led_out = next_s.led_set;
		end

		next_s.int_oe = next_s.ready
		              & next_s.plain[`INT_CTL_INDEX][`INT_READY_EN_BIT]; // R17
	end

	// -------------------------------------------------------------
	// state register
	// -------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s         <= '0;
			s.scl_d   <= 1'b1;
			s.sda_d   <= 1'b1;
			s.rate    <= `RATE_RESET;
			s.led_set <= `LED_RESET;
			s.led_out <= `LED_RESET;
		end else begin
			s <= next_s;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign sda_o         = 1'b0;
	assign sda_oe_o      = s.sda_oe;
	assign int_o         = 1'b0; // R17
	assign int_oe_o      = s.int_oe;
	assign meas_active_o = s.busy;
	assign led_current_o = s.led_out;

endmodule : prox_sensor_top
`default_nettype wire

// >>> rtl/sync2.sv
// two-stage synchroniser for pin inputs
// assumes inputs are asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_t;

	sync_state_t s;
	sync_state_t next_s;

	// first stage feeds only the second one
	always_comb begin
		next_s.meta   = async_i;
		next_s.stable = s.meta;
	end

	// reset to the idle level of the pulled-up pins, so that
	// no false edge is seen right after reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '1;
		end else begin
			s <= next_s;
		end
	end

	assign sync_o = s.stable;

endmodule : sync2
`default_nettype wire

// >>> verif/i2c_host_model.sv
// I2C bus controller model standing in for the host
// assumes pull-ups on SDA and SCL; SCL stands high between frames
`timescale 1ns/1ps
`default_nettype none
`include "prox_consts.svh"

module i2c_host_model (
	input  wire logic clk_i,
	output logic      scl_o,
	output logic      sda_pull_o,
	input  wire logic sda_i
);
	logic in_frame;

	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
		in_frame = 1'b0;
	end

	// ------------------------------------------------------------
	// bit level
	// ------------------------------------------------------------
	// pins move only just after a clock edge, so the synchroniser never races them
	task automatic tk(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tk

	// eight clocks a bit (200 ns); the target answers within 3 clocks of a fall
	task automatic bit_x(input logic low, output logic seen);
		@(posedge clk_i);
		scl_o <= 1'b0;
		tk(3);
		sda_pull_o <= low;
		tk(2);
		scl_o <= 1'b1;
		tk(2);
		seen = sda_i;
	endtask : bit_x

	task automatic start_x();
		if (in_frame) begin
			@(posedge clk_i);
			scl_o <= 1'b0;
			tk(3);
			sda_pull_o <= 1'b0;
			tk(2);
			scl_o <= 1'b1;
		end
		tk(4);
		sda_pull_o <= 1'b1;
		tk(4);
		in_frame = 1'b1;
	endtask : start_x

	task automatic stop_x();
		@(posedge clk_i);
		scl_o <= 1'b0;
		tk(3);
		sda_pull_o <= 1'b1;
		tk(2);
		scl_o <= 1'b1;
		tk(4);
		sda_pull_o <= 1'b0;
		tk(4);
		in_frame = 1'b0;
	endtask : stop_x

	// msb first; the ninth bit is the acknowledge
	task automatic byte_x(input logic [7:0] tx, input logic rd, input logic last,
		output logic [7:0] rx, output logic acked);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_x(!rd && !tx[i], b);
			rx[i] = b;
		end
		bit_x(rd && !last, b);
		acked = !b;
	endtask : byte_x

	// ------------------------------------------------------------
	// transactions
	// ------------------------------------------------------------
	task automatic probe(input logic [7:0] ab, output logic acked);
		logic [7:0] r;
		start_x();
		byte_x(ab, 1'b0, 1'b0, r, acked);
		stop_x();
	endtask : probe

	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic k;
		start_x();
		byte_x({`DEV_ADDR7, 1'b0}, 1'b0, 1'b0, r, k);
		byte_x(a, 1'b0, 1'b0, r, k);
		byte_x(d, 1'b0, 1'b0, r, k);
		stop_x();
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] r;
		logic k;
		start_x();
		byte_x({`DEV_ADDR7, 1'b0}, 1'b0, 1'b0, r, k);
		byte_x(a, 1'b0, 1'b0, r, k);
		start_x();
		byte_x({`DEV_ADDR7, 1'b1}, 1'b0, 1'b0, r, k);
		byte_x(8'hFF, 1'b1, 1'b1, d, k);
		stop_x();
	endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

// >>> verif/prox_sensor_top_properties.sv
// port checker for the proximity sensor control block
// assumes one clock domain with an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "prox_consts.svh"

module prox_sensor_top_checker (
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              sda_o,
	input wire logic              sda_oe_o,
	input wire logic              int_o,
	input wire logic              int_oe_o,
	input wire logic              meas_active_o,
	input wire logic [`LED_W-1:0] led_current_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic [11:0] conv_len;

	// ------------------------------------------------------------
	// conversion length counter
	// ------------------------------------------------------------
	// a counter, because a repetition of 400 would choke the tools
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			conv_len <= 12'h000;
		else if (meas_active_o)
			conv_len <= conv_len + 12'h001;
		else
			conv_len <= 12'h000;
	end

	property p_int_od; int_o == 1'b0; endproperty
	property p_sda_od; sda_o == 1'b0; endproperty
	property p_conv_len; $fell(meas_active_o) |-> conv_len == 12'(`CONV_CYCLES); endproperty
	property p_conv_max; meas_active_o |-> conv_len < 12'(`CONV_CYCLES); endproperty
	property p_conv_gap; $fell(meas_active_o) |=> !meas_active_o; endproperty
	property p_rst_val;
		$fell(rst_i) |-> led_current_o == `LED_RESET && !sda_oe_o && !int_oe_o && !meas_active_o;
	endproperty
	property p_ack_min; $rose(sda_oe_o) |-> sda_oe_o [*4]; endproperty
	property p_ack_max; $rose(sda_oe_o) |-> ##[1:100] !sda_oe_o; endproperty

	a_int_od: assert property (p_int_od) else $error("int pin driven high");
	a_sda_od: assert property (p_sda_od) else $error("sda pin driven high");
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
	a_conv_max: assert property (p_conv_max) else $error("conversion overran");
	a_conv_gap: assert property (p_conv_gap) else $error("conversion restarted at once");
	a_rst_val: assert property (p_rst_val) else $error("outputs wrong after reset");
	a_ack_min: assert property (p_ack_min) else $error("sda pull too short");
	a_ack_max: assert property (p_ack_max) else $error("sda held too long");

	c_conv: cover property ($fell(meas_active_o));
	c_int: cover property ($rose(int_oe_o));
	c_ack: cover property ($rose(sda_oe_o));
endmodule : prox_sensor_top_checker

bind prox_sensor_top prox_sensor_top_checker chk_u (
	.clk_i(clk_i), .rst_i(rst_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .int_o(int_o),
	.int_oe_o(int_oe_o), .meas_active_o(meas_active_o), .led_current_o(led_current_o));
`default_nettype wire

// >>> verif/proximity_sensor_i2c_control_test.sv
// self-checking bench for the proximity sensor control block
// assumes the host model drives the I2C pins; SDA has a pull-up
`timescale 1ns/1ps
`default_nettype none
`include "prox_consts.svh"

module proximity_sensor_i2c_control_test;
	logic                 clk_i;
	logic                 rst_i;
	logic [`RESULT_W-1:0] meas_sample_i;
	wire logic            scl_line;
	wire logic            sda_pull;
	wire logic            sda_line;
	logic                 sda_o;
	logic                 sda_oe_o;
	logic                 int_o;
	logic                 int_oe_o;
	logic                 meas_active_o;
	logic [`LED_W-1:0]    led_current_o;
	int                   n_mismatch = 0;
	int                   n_tests = 0;
	int                   n_conv = 0;
	int                   c0;
	logic [7:0]           rd_v;
	logic                 ack;

	// open drain: high unless either party pulls low
	assign sda_line = !sda_pull && (sda_oe_o ? sda_o : 1'b1);

	prox_sensor_top #(.RATE_BASE_CYCLES(800)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_line), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .int_o(int_o), .int_oe_o(int_oe_o), .meas_sample_i(meas_sample_i),
		.meas_active_o(meas_active_o), .led_current_o(led_current_o));

	i2c_host_model host_u (.clk_i(clk_i), .scl_o(scl_line), .sda_pull_o(sda_pull), .sda_i(sda_line));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	always @(posedge meas_active_o) n_conv++;

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
		host_u.read_reg(a, rd_v);
		check(what, {8'h00, rd_v}, {8'h00, exp});
	endtask : rdc

	// bounded waits for one conversion to start and end
	task automatic wait_conv();
		for (int k = 0; k < 600 && meas_active_o !== 1'b1; k++) @(posedge clk_i);
		for (int k = 0; k < 600 && meas_active_o !== 1'b0; k++) @(posedge clk_i);
		check("conv_end", {15'h0000, meas_active_o}, 16'h0000);
		repeat (2) @(posedge clk_i);
	endtask : wait_conv

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up

	// whole run is about 12,000 clocks; allow five times that
	initial begin
		#1500000;
		n_mismatch++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		meas_sample_i = 16'h0000;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		check("led_reset", {10'h000, led_current_o}, 16'h0002);
		rdc(8'h80, 8'h80, "cmd_reset");
		rdc(8'h7F, 8'h00, "unmapped");
		// of 24h, 26h and 28h only 26h, the write address byte of the fixed target, is acknowledged
		for (int i = 0; i < 3; i++) begin
			host_u.probe(8'h24 + 8'(2 * i), ack);
			check("addr_ack", {15'h0000, ack}, {15'h0000, i == 1});
		end
		host_u.write_reg(8'h80, 8'h00);
		rdc(8'h80, 8'h80, "lock_bit");
		host_u.write_reg(8'h82, 8'h07);
		rdc(8'h82, 8'h07, "rate_rw");
		host_u.write_reg(8'h82, 8'h00);
		host_u.write_reg(8'h83, 8'h15);
		check("led_set", {10'h000, led_current_o}, 16'h0015);
		// single shots with the interrupt on; each result byte clears ready
		host_u.write_reg(8'h89, 8'h08);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			meas_sample_i <= i ? 16'h3C96 : 16'hA5C3;
			host_u.write_reg(8'h80, 8'h08);
			wait_conv();
			check("int_set", {14'h0000, int_oe_o, int_o}, 16'h0002);
			rdc(8'h80, 8'hA0, "ready_set");
			rdc(8'h87 + 8'(i), i ? 8'h96 : 8'hA5, "result");
			rdc(8'h80, 8'h80, "ready_clear");
			check("int_clear", {15'h0000, int_oe_o}, 16'h0000);
		end
		// self-timed alone starts nothing and blocks single shots
		host_u.write_reg(8'h80, 8'h01);
		c0 = n_conv;
		host_u.write_reg(8'h80, 8'h09);
		repeat (1000) @(posedge clk_i);
		check("no_conv", 16'(n_conv - c0), 16'h0000);
		host_u.write_reg(8'h82, 8'h07);
		rdc(8'h82, 8'h00, "rate_locked");
		rdc(8'h80, 8'h81, "selftimed_rd");
		host_u.write_reg(8'h83, 8'h0A);
		check("led_held", {10'h000, led_current_o}, 16'h0015);
		// periodic: ticks every 800 cycles at rate 0
		host_u.write_reg(8'h80, 8'h03);
		c0 = n_conv;
		repeat (1800) @(posedge clk_i);
		check("periodic", 16'(n_conv - c0), 16'h0002);
		rdc(8'h80, 8'hA3, "periodic_rd");
		host_u.write_reg(8'h80, 8'h00);
		c0 = n_conv;
		repeat (1000) @(posedge clk_i);
		check("stopped", 16'(n_conv - c0), 16'h0000);
		check("led_taken", {10'h000, led_current_o}, 16'h000A);
		wrap_up();
	end
endmodule : proximity_sensor_i2c_control_test
`default_nettype wire
